// [dv/oscsw_ctrl_tb.sv]
// Self-checking testbench of the oscillator switch controller
`timescale 1ns/1ps
module oscsw_ctrl_tb
  import oscsw_pkg::*;
;
  localparam int OST_N = 4;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  oscsw_cfg_s  cfg;
  oscsw_osc_s  osc_tick;
  logic        pll_locked;
  logic        osc_fail;
  logic        sleep;
  oscsw_osc_s  osc_en;
  logic [2:0]  sys_src;
  logic [8:0]  pll_fb;
  logic [5:0]  trim;
  logic        trap;
  logic [31:0] rdat;
  logic [1:0]  rrsp;
  logic [1:0]  wresp;
  logic [31:0] rnd;
  logic [31:0] v;
  logic [31:0] seed = 32'h0252aed4;
  int          miscompares = 0;
  int          total_checks = 0;
  int          tcnt = 0;
  int          traps = 0;
  int          tsel = 4;
  int          t;

  oscsw_ctrl #(.OST_TICKS(OST_N)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cfg(cfg), .osc_tick(osc_tick), .pll_locked(pll_locked), .osc_fail(osc_fail),
    .sleep_mode(sleep), .osc_en(osc_en), .sys_src(sys_src), .pll_feedback_factor(pll_fb),
    .rc_trim_value(trim), .clock_fail_trap(trap)
  );

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Random oscillator ticks, counts of target ticks and traps
  always @(posedge aclk)
  begin
    rnd = $random(seed);
    osc_tick <= rnd[4:0];
    if (osc_tick[tsel]) tcnt <= tcnt + 1;
    if (trap === 1'b1) traps <= traps + 1;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic tmo();
    miscompares++;
    final_report();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic at, wt, bt;
    @(posedge aclk);
    n = 0;
    bt = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!bt && n < 100)
    begin
      @(negedge aclk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid && bready;
      wresp = bresp;
      @(posedge aclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      if (bt) bready <= 1'b0;
      n++;
    end
    if (!bt) tmo();
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    logic at, rt;
    @(posedge aclk);
    n = 0;
    rt = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!rt && n < 100)
    begin
      @(negedge aclk);
      at = arvalid && arready;
      rt = rvalid && rready;
      rdat = rdata;
      rrsp = rresp;
      @(posedge aclk);
      if (at) arvalid <= 1'b0;
      if (rt) rready <= 1'b0;
      n++;
    end
    if (!rt) tmo();
  endtask

  // Unlocked write of the control register
  task automatic ctl(input logic [2:0] ns, input logic [7:0] lo);
    wr(ADDR_UNLOCK, UNLOCK_KEY);
    t = tcnt;
    wr(ADDR_OSC_CTRL, {16'h0, 5'h0, ns, lo});
  endtask

  function automatic int tick_bit(input oscsw_src_e s);
    case (s)
      SRC_PRI, SRC_PRI_PLL: return 3;
      SRC_SEC: return 2;
      SRC_LOW_POWER_RC: return 1;
      default: return 4;
    endcase
  endfunction

  // Full switch: hold keeps PLL unlocked, mint is least target ticks
  task automatic sw(input oscsw_src_e s, input int hold, input int mint);
    int n;
    logic [2:0] old;
    old = sys_src;
    tsel = tick_bit(s);
    ctl(s, 8'h01);
    repeat (hold) @(posedge aclk);
    chk(sys_src, old);
    pll_locked <= 1'b1;
    n = 0;
    while (sys_src !== s && n < 2000)
    begin
      @(negedge aclk);
      n++;
    end
    if (n == 2000) tmo();
    chk(tcnt - t >= mint, 1);
    rd(ADDR_OSC_CTRL);
    chk(rdat[14:12], s);
    chk(rdat[0], 0);
    chk(rdat[3], 0);
  endtask

  task automatic fail(input logic [2:0] exp);
    t = traps;
    osc_fail <= 1'b1;
    @(posedge aclk);
    osc_fail <= 1'b0;
    repeat (5) @(negedge aclk);
    chk(traps - t, 1);
    chk(sys_src, exp);
    rd(ADDR_OSC_CTRL);
    chk(rdat[3], 1);
  endtask

  initial
  begin
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    cfg = '{1'b1, 1'b0, SRC_FRC, 1'b0, 1'b0};
    osc_tick = '0;
    sleep = 1'b0;
    pll_locked = 1'b0;
    osc_fail = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_PLL_MULT);
    chk(rdat, 32'h30);
    rd(ADDR_RC_TUNE);
    chk(rdat, 32'h0);
    rd(ADDR_OSC_CTRL);
    chk(rdat[14:12], SRC_FRC);
    chk(rdat[7:0], 8'h0);
    for (int i = 0; i < 6; i++)
    begin
      v = $random(seed);
      if (i == 0) v[8:0] = 9'h1ff;
      if (i == 1) v[5:0] = 6'h20;
      if (i == 2) v[5:0] = 6'h1f;
      wr(ADDR_PLL_MULT, v);
      rd(ADDR_PLL_MULT);
      chk(rdat, {23'h0, v[8:0]});
      chk(pll_fb, v[8:0]);
      wr(ADDR_RC_TUNE, v);
      rd(ADDR_RC_TUNE);
      chk(rdat, {26'h0, v[5:0]});
      chk(trim, v[5:0]);
    end
    wr(8'h14, 32'h1);
    chk(wresp, RESP_SLVERR);
    rd(8'h20);
    chk({rrsp, rdat}, {RESP_SLVERR, 32'h0});
    ctl(SRC_SEC, 8'h01);
    rd(ADDR_OSC_CTRL);
    chk(rdat[0], 0);
    chk(rdat[14:12], SRC_FRC);
    repeat (40) @(posedge aclk);
    chk(sys_src, SRC_FRC);
    cfg.switch_enable_config <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(osc_en.low_power_rc, 1);
    sleep <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(osc_en.low_power_rc, 0);
    sleep <= 1'b0;
    repeat (2) @(posedge aclk);
    wr(ADDR_OSC_CTRL, {21'h0, SRC_SEC, 8'h01});
    rd(ADDR_OSC_CTRL);
    chk(rdat[0], 0);
    chk(sys_src, SRC_FRC);
    ctl(SRC_FRC, 8'h01);
    rd(ADDR_OSC_CTRL);
    chk(rdat[0], 0);
    rd(ADDR_STATUS);
    chk(rdat[6:5], 2'h0);
    sw(SRC_SEC, 0, 10);
    chk({osc_en.fast_rc_source, osc_en.sec}, 2'b01);
    sw(SRC_FRC, 0, 10);
    pll_locked <= 1'b0;
    sw(SRC_FRC_PLL, 30, 10);
    fail(SRC_FRC_PLL);
    sw(SRC_FRC, 0, 10);
    cfg.primary_is_crystal <= 1'b1;
    sw(SRC_PRI, 0, OST_N + 10);
    fail(SRC_FRC);
    ctl(SRC_FRC, 8'h00);
    rd(ADDR_OSC_CTRL);
    chk(rdat[3], 0);
    cfg.lock_permit_config <= 1'b1;
    ctl(SRC_FRC, 8'h80);
    wr(ADDR_PLL_MULT, 32'h0aa);
    chk(pll_fb, v[8:0]);
    final_report();
  end
endmodule

// [rtl/oscsw_ctrl.sv]
// Oscillator selection, clock switch sequencer and fail-safe monitor
//
// What this block does
// - PLL multiplier is 9 bits, factor is value plus two, reset 50.
// - RC trim is 6-bit two's complement, 0.375 percent steps, resets zero.
// - Switching and fail monitor only work when switch-enable config is zero.
// - Switching off: new-source field ignored, current shows initial config.
// - Switching off: switch request bit held at zero.
// - Request with new equal to current clears request, does nothing else.
// - Real switch start clears PLL lock status and clock-fail flag.
// - Enable new source, wait crystal timer and PLL lock as needed.
// - After ready, count ten new-source cycles, then change over.
// - On changeover clear request and copy new source to current.
// - Turn old source off, except LOW_POWER_RC for watchdog/monitor, secondary if enabled.
// - Switching runs in background, never stalls the processor.
// - Monitor enabled keeps LOW_POWER_RC running except in sleep.
// - Oscillator failure raises trap and forces clock to fast RC.
// - Failure while on PLL falls back to fast RC with PLL.
// - Source codes 000 to 111 as enumerated in the package.
// - Clock-fail flag set by monitor, stays until software clears or a real switch starts.
// - Clock lock bit with lock permit config freezes clock and PLL setup.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module oscsw_ctrl
  import oscsw_pkg::*;
#(
  parameter int OST_TICKS = OST_TICKS_DEF
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire oscsw_cfg_s  cfg,
  input  wire oscsw_osc_s  osc_tick,
  input  wire logic        pll_locked,
  input  wire logic        osc_fail,
  input  wire logic        sleep_mode,
  output oscsw_osc_s       osc_en,
  output logic [2:0]       sys_src,
  output logic [8:0]       pll_feedback_factor,
  output logic [5:0]       rc_trim_value,
  output logic             clock_fail_trap
);
  initial
  begin
    if (OST_TICKS < 1 || OST_TICKS > 2047)
      $error("OST_TICKS out of range");
  end

  oscsw_state_e state_r;
  logic [2:0]   cur_r;
  logic [2:0]   new_source_select_r;
  logic [2:0]   tgt_r;
  logic         sw_req_r;
  logic         clk_lock_r;
  logic         pll_lock_r;
  logic         cf_r;
  logic         sec_en_r;
  logic         unlock_r;
  logic [10:0]  cnt_r;
  logic         trap_r;
  logic         aw_hold_r;
  logic         w_hold_r;
  logic [7:0]   awaddr_r;
  logic [31:0]  wdata_r;
  logic [3:0]   wstrb_r;
  logic         sw_en;
  logic         locked;
  logic         fail_ev;
  logic         wr_go;
  logic         wr_ctrl;
  logic         wr_hi;
  logic         wr_lo;
  logic         start;
  logic         finish;
  logic         need_ost;
  logic         ready;
  logic         tgt_tick;
  logic         cur_pll;

  function automatic logic is_frc(input logic [2:0] s);
    is_frc = (s == SRC_FRC) || (s == SRC_FRC_PLL) || (s == SRC_FRC_D16) || (s == SRC_FRC_DN);
  endfunction

  function automatic logic is_pri(input logic [2:0] s);
    is_pri = (s == SRC_PRI) || (s == SRC_PRI_PLL);
  endfunction

  function automatic logic uses_pll(input logic [2:0] s);
    uses_pll = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
  endfunction

  function automatic logic tick_of(input logic [2:0] s, input oscsw_osc_s t);
    tick_of = (is_frc(s) & t.fast_rc_source) | (is_pri(s) & t.pri) | ((s == SRC_SEC) & t.sec)
            | ((s == SRC_LOW_POWER_RC) & t.low_power_rc);
  endfunction

  assign sw_en    = ~cfg.switch_enable_config;
  assign locked   = clk_lock_r & cfg.lock_permit_config;
  assign fail_ev  = sw_en & osc_fail & ~sleep_mode;
  assign cur_pll  = uses_pll(cur_r);
  assign start    = (state_r == ST_IDLE) & sw_req_r & sw_en & (new_source_select_r != cur_r) & ~fail_ev;
  assign need_ost = is_pri(tgt_r) & ~is_pri(cur_r) & cfg.primary_is_crystal;
  assign ready    = (~need_ost | (cnt_r >= 11'(OST_TICKS)))
                  & (~uses_pll(tgt_r) | pll_lock_r);
  assign tgt_tick = tick_of(tgt_r, osc_tick);
  assign finish   = (state_r == ST_HAND) & tgt_tick & (cnt_r[3:0] == HANDOVER_TICKS - 4'h1);

  // AXI4-Lite write channel, address and data taken in either order
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  assign wr_go   = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign wr_ctrl = wr_go & (awaddr_r == ADDR_OSC_CTRL) & unlock_r;
  assign wr_hi   = wr_ctrl & wstrb_r[1];
  assign wr_lo   = wr_ctrl & wstrb_r[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r <= ADDR_STATUS && awaddr_r[1:0] == 2'h0) ? RESP_OKAY
                                                                          : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel, one cycle answer
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      case (s_axi_araddr)
        ADDR_OSC_CTRL:
          s_axi_rdata <= {17'h0, cur_r, 1'b0, new_source_select_r, clk_lock_r, 1'b0, pll_lock_r, 1'b0,
                          cf_r, 1'b0, sec_en_r, sw_req_r};
        ADDR_PLL_MULT: s_axi_rdata <= {23'h0, pll_feedback_factor};
        ADDR_RC_TUNE:  s_axi_rdata <= {26'h0, rc_trim_value};
        ADDR_UNLOCK:   s_axi_rdata <= {31'h0, unlock_r};
        ADDR_STATUS:   s_axi_rdata <= {25'h0, state_r, osc_en};
        default:       s_axi_rresp <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // One-shot unlock, spent by the next control register write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      unlock_r <= 1'b0;
    else if (wr_go && awaddr_r == ADDR_UNLOCK)
      unlock_r <= (wdata_r == UNLOCK_KEY);
    else if (wr_go && awaddr_r == ADDR_OSC_CTRL)
      unlock_r <= 1'b0;
  end

  // PLL multiplier and RC trim
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_feedback_factor <= PLL_MULT_RST;
      rc_trim_value       <= RC_TRIM_RST;
    end
    else if (wr_go)
    begin
      if (awaddr_r == ADDR_PLL_MULT && !locked)
      begin
        if (wstrb_r[0])
          pll_feedback_factor[7:0] <= wdata_r[7:0];
        if (wstrb_r[1])
          pll_feedback_factor[8] <= wdata_r[8];
      end
      if (awaddr_r == ADDR_RC_TUNE && wstrb_r[0])
        rc_trim_value <= wdata_r[5:0];
    end
  end

  // Software-held control bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      new_source_select_r     <= cfg.initial_source_config;
      clk_lock_r <= 1'b0;
      sec_en_r   <= 1'b0;
    end
    else
    begin
      if (wr_hi && !locked)
        new_source_select_r <= wdata_r[NEW_LSB +: 3];
      if (wr_lo)
      begin
        clk_lock_r <= wdata_r[CLK_LOCK_BIT];
        sec_en_r   <= wdata_r[SEC_EN_BIT];
      end
    end
  end

  // Switch request: software set wins over hardware clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sw_en)
      sw_req_r <= 1'b0;
    else if (wr_lo && wdata_r[SW_REQ_BIT] && !locked)
      sw_req_r <= 1'b1;
    else if (fail_ev || finish)
      sw_req_r <= 1'b0;
    else if (state_r == ST_IDLE && sw_req_r && new_source_select_r == cur_r)
      sw_req_r <= 1'b0;
  end

  // Clock-fail flag, sticky; monitor set wins over any clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cf_r <= 1'b0;
    else if (fail_ev)
      cf_r <= 1'b1;
    else if (start)
      cf_r <= 1'b0;
    else if (wr_lo && !wdata_r[FAIL_BIT])
      cf_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || start)
      pll_lock_r <= 1'b0;
    else
      pll_lock_r <= osc_en.pll & pll_locked;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trap_r <= 1'b0;
    else
      trap_r <= fail_ev;
  end
  assign clock_fail_trap = trap_r;

  // Background switch sequencer; the core is never held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_IDLE;
      cur_r   <= cfg.initial_source_config;
      tgt_r   <= cfg.initial_source_config;
      cnt_r   <= 11'h000;
    end
    else if (!sw_en)
    begin
      state_r <= ST_IDLE;
      cur_r   <= cfg.initial_source_config;
    end
    else if (fail_ev)
    begin
      state_r <= ST_IDLE;
      cur_r   <= cur_pll ? SRC_FRC_PLL : SRC_FRC;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (start)
          begin
            tgt_r   <= new_source_select_r;
            cnt_r   <= 11'h000;
            state_r <= ST_WAIT;
          end
        ST_WAIT:
          if (ready)
          begin
            cnt_r   <= 11'h000;
            state_r <= ST_HAND;
          end
          else if (tgt_tick && cnt_r < 11'(OST_TICKS))
            cnt_r <= cnt_r + 11'h001;
        ST_HAND:
          if (finish)
          begin
            cur_r   <= tgt_r;
            state_r <= ST_IDLE;
          end
          else if (tgt_tick)
            cnt_r <= cnt_r + 11'h001;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Oscillator enables: current, pending target, and kept-alive sources
  always_comb
  begin
    logic busy;
    busy         = (state_r != ST_IDLE);
    osc_en.fast_rc_source   = is_frc(cur_r) | (busy & is_frc(tgt_r));
    osc_en.pri   = is_pri(cur_r) | (busy & is_pri(tgt_r));
    osc_en.sec   = (cur_r == SRC_SEC) | (busy & (tgt_r == SRC_SEC)) | sec_en_r;
    osc_en.low_power_rc  = (cur_r == SRC_LOW_POWER_RC) | (busy & (tgt_r == SRC_LOW_POWER_RC))
                 | ((cfg.wdt_enable | sw_en) & ~sleep_mode);
    osc_en.pll   = cur_pll | (busy & uses_pll(tgt_r));
  end
  assign sys_src = cur_r;

  property p_redundant;
    @(posedge aclk) disable iff (!aresetn)
    (state_r == ST_IDLE && sw_req_r && sw_en && new_source_select_r == cur_r && !wr_lo && !fail_ev)
      |=> !sw_req_r && state_r == ST_IDLE;
  endproperty
  a_redundant: assert property (p_redundant) else $error("redundant switch not dropped");

  property p_osw_held;
    @(posedge aclk) disable iff (!aresetn)
    !sw_en [*2] |-> !sw_req_r;
  endproperty
  a_osw_held: assert property (p_osw_held) else $error("request set while disabled");

  property p_disabled_src;
    @(posedge aclk) disable iff (!aresetn)
    !sw_en |=> sys_src == $past(cfg.initial_source_config);
  endproperty
  a_disabled_src: assert property (p_disabled_src) else $error("source not from config");

  property p_start_clear;
    @(posedge aclk) disable iff (!aresetn)
    start |=> !pll_lock_r && !cf_r && state_r == ST_WAIT;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start did not clear flags");

  property p_finish;
    @(posedge aclk) disable iff (!aresetn)
    (finish && sw_en && !fail_ev) |=> sys_src == $past(tgt_r) && state_r == ST_IDLE;
  endproperty
  a_finish: assert property (p_finish) else $error("changeover not applied");

  property p_ten_ticks;
    @(posedge aclk) disable iff (!aresetn)
    finish |-> cnt_r == 11'h009 && state_r == ST_HAND;
  endproperty
  a_ten_ticks: assert property (p_ten_ticks) else $error("handover count wrong");

  property p_fail;
    @(posedge aclk) disable iff (!aresetn)
    fail_ev |=> clock_fail_trap && cf_r && is_frc(sys_src) && sys_src[2:1] == 2'h0
      && sys_src[0] == $past(cur_pll);
  endproperty
  a_fail: assert property (p_fail) else $error("failure fallback wrong");

  property p_low_power_rc;
    @(posedge aclk) disable iff (!aresetn)
    (sw_en && !sleep_mode) |-> osc_en.low_power_rc;
  endproperty
  a_low_power_rc: assert property (p_low_power_rc) else $error("LOW_POWER_RC stopped with monitor on");

  property p_cf_sticky;
    @(posedge aclk) disable iff (!aresetn)
    (cf_r && !start && !(wr_lo && !wdata_r[FAIL_BIT])) |=> cf_r;
  endproperty
  a_cf_sticky: assert property (p_cf_sticky) else $error("fail flag lost");

  property p_wait_ready;
    @(posedge aclk) disable iff (!aresetn)
    (state_r == ST_WAIT && !ready) |=> state_r != ST_HAND;
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("handover before ready");

  c_switch: cover property (@(posedge aclk) disable iff (!aresetn) finish);
  c_redundant: cover property (@(posedge aclk) disable iff (!aresetn)
    state_r == ST_IDLE && sw_req_r && sw_en && new_source_select_r == cur_r);
  c_fail: cover property (@(posedge aclk) disable iff (!aresetn) fail_ev && cur_pll);
  c_ost: cover property (@(posedge aclk) disable iff (!aresetn) state_r == ST_WAIT && need_ost);
endmodule

// [rtl/oscsw_pkg.sv]
// Constants, types and register map of the oscillator switch controller
package oscsw_pkg;
  localparam logic [7:0]  ADDR_OSC_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_PLL_MULT  = 8'h04;
  localparam logic [7:0]  ADDR_RC_TUNE   = 8'h08;
  localparam logic [7:0]  ADDR_UNLOCK    = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS    = 8'h10;
  localparam logic [31:0] UNLOCK_KEY     = 32'h0000_a55a;
  // Control register field positions
  localparam int          CUR_LSB        = 12;
  localparam int          NEW_LSB        = 8;
  localparam int          CLK_LOCK_BIT   = 7;
  localparam int          PLL_LOCK_BIT   = 5;
  localparam int          FAIL_BIT       = 3;
  localparam int          SEC_EN_BIT     = 1;
  localparam int          SW_REQ_BIT     = 0;
  // Reset values
  localparam logic [8:0]  PLL_MULT_RST   = 9'h030;
  localparam logic [5:0]  RC_TRIM_RST    = 6'h00;
  // Timing counts in cycles of the new source
  localparam logic [3:0]  HANDOVER_TICKS = 4'ha;
  localparam int          OST_TICKS_DEF  = 1024;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    SRC_FRC      = 3'h0,
    SRC_FRC_PLL  = 3'h1,
    SRC_PRI      = 3'h2,
    SRC_PRI_PLL  = 3'h3,
    SRC_SEC      = 3'h4,
    SRC_LOW_POWER_RC     = 3'h5,
    SRC_FRC_D16  = 3'h6,
    SRC_FRC_DN   = 3'h7
  } oscsw_src_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_HAND = 2'h2
  } oscsw_state_e;

  // One bit per oscillator: enables out, clock ticks in
  typedef struct packed {
    logic fast_rc_source;
    logic pri;
    logic sec;
    logic low_power_rc;
    logic pll;
  } oscsw_osc_s;

  typedef struct packed {
    logic switch_enable_config;
    logic lock_permit_config;
    logic [2:0] initial_source_config;
    logic primary_is_crystal;
    logic wdt_enable;
  } oscsw_cfg_s;
endpackage
